// >>> bench/testbench.sv
`timescale 1ns/1ps
// ==========================================
// bench for the control decode stage
module testbench;
    import uword_ctl_pkg::*;
    logic        clk_i, rst_i, start_i, npr_request_i, wb_we_i, wb_cyc_i, wb_stb_i;
    logic        wb_ack_o, word_load_o, ps_load_cc_o, ps_cc_from_ir_o, ps_load_word_o;
    logic        begin_bus_o, odd_error_o, stack_error_o, npr_grant_o, clk_bus_addr_o;
    logic        clk_d_reg_o, clk_b_reg_o, write_low_o, write_high_o, clk_instr_reg_o;
    logic        examine_flag_o, deposit_flag_o, run_o, idle_o, overlap_permit_o, exam, dep;
    logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
    logic [15:0] bus_addr_data_o, dmux_o, alu_b_o;
    logic [4:0]  alu_op_o;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [2:0]  cycle_select_o;
    logic [1:0]  bus_ctl_o, last_ctl;
    microword_t  rom_word_i;
    datapath_t   dp_i;
    int          n_mismatch, n_compared, cyc;
    int          q_wl [$];
    microword_control_decode microword_control_decode_i (.*);
    uword_rom_model uword_rom_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .word_load_i(word_load_o), .rom_word_o(rom_word_i));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // wishbone single cycle
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // ==========================================
    // load a program, start it, compare with model
    task automatic run_prog(input int base, input int n, input logic pin);
        microword_t w;
        int         k, sum, q0;
        sum = 0;
        q0 = q_wl.size();
        for (k = 0; k < n; k++)
        begin
            w = microword_t'(35'({xs(), xs()}));
            w.data_alteration_code = 4'(base + n - 1 - k);
            w.b_constant_select = 4'(base + k);
            w.cycle_length_code = 2'(base + k);
            w.clock_stop = (k == n - 1);
            uword_rom_model_i.rom[base + k] = w;
            if (k < n - 1)
                sum += w.cycle_length_code == 2'h3 ? LONG_CYC :
                       w.cycle_length_code == 2'h2 ? MEDIUM_CYC : SHORT_CYC;
            exam = w.data_alteration_code == ALT_SET_EXAM ? 1'b1 :
                   w.data_alteration_code == ALT_CLR_EXAM ? 1'b0 : exam;
            dep = w.data_alteration_code == ALT_SET_DEP ? 1'b1 :
                  w.data_alteration_code == ALT_CLR_DEP ? 1'b0 : dep;
            if (w.begin_bus_cycle)
                last_ctl = w.bus_ctl;
        end
        if (pin)
        begin
            start_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            start_i <= 1'b0;
        end
        else
            wb(1'b1, REG_CONTROL, 32'h1, rd);
        while (q_wl.size() < q0 + n || idle_o !== 1'b1)
            @(posedge clk_i);
        repeat (12) @(posedge clk_i);
        check(32'(q_wl.size() - q0), 32'(n));
        check(32'(q_wl[q0 + n - 1] - q_wl[q0]), 32'(sum));
        check({26'h0, examine_flag_o, deposit_flag_o, bus_ctl_o, run_o, idle_o},
              {26'h0, exam, dep, last_ctl, 2'b01});
        wb(1'b0, REG_WORD, 32'h0, rd);
        check(rd, {16'h0, w[15:0]});
        wb(1'b1, REG_CONTROL, 32'h2, rd);
        repeat (2) @(posedge clk_i);
        check({30'h0, odd_error_o, stack_error_o}, 32'h0);
        $display("program test done");
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        dp_i <= datapath_t'(85'({xs(), xs(), xs()}));
        npr_request_i <= seed[3];
        if (word_load_o === 1'b1)
            q_wl.push_back(cyc);
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
    initial
    begin
        {n_mismatch, n_compared, cyc, exam, dep, last_ctl} = '0;
        {start_i, npr_request_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
        {rst_i, wb_sel_i, seed} = {1'b1, 4'hf, 32'h3d};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({30'h0, run_o, idle_o}, 32'h1);
        wb(1'b0, REG_STACK_LIMIT, 32'h0, rd);
        check(rd, 32'(STACK_LIMIT_RST));
        wb(1'b1, REG_STACK_LIMIT, 32'h0000beef, rd);
        wb(1'b0, REG_STACK_LIMIT, 32'h0, rd);
        check(rd, 32'h0000beef);
        wb(1'b0, 4'h2, 32'h0, rd);
        check(rd, 32'h0);
        $display("register test done");
        run_prog(0, 8, 1'b0);
        run_prog(8, 8, 1'b1);
        conclude();
    end
endmodule

// >>> bench/uword_ctl_sva.sv
`timescale 1ns/1ps
// ==========================================
// control stage checks
module uword_ctl_sva
(
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire uword_ctl_pkg::microword_t rom_word_i,
    input wire uword_ctl_pkg::datapath_t  dp_i,
    input wire logic                      word_load_o,
    input wire logic [15:0]               bus_addr_data_o,
    input wire logic [15:0]               dmux_o,
    input wire logic [15:0]               alu_b_o,
    input wire logic [4:0]                alu_op_o,
    input wire logic                      begin_bus_o,
    input wire logic [1:0]                bus_ctl_o,
    input wire logic                      clk_bus_addr_o,
    input wire logic                      clk_d_reg_o,
    input wire logic                      clk_b_reg_o,
    input wire logic                      write_low_o,
    input wire logic                      write_high_o,
    input wire logic                      clk_instr_reg_o,
    input wire logic                      run_o,
    input wire logic                      idle_o
);
    import uword_ctl_pkg::*;
    microword_t  prev, uw, cur;
    logic        ok;
    logic [3:0]  age, len;
    logic [1:0]  ds, ls, hs;
    logic [15:0] b, kc, e_ba, e_dm, e_b;
    logic [4:0]  e_op;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // buffered word as seen at the ports
    assign cur = word_load_o ? prev : uw;
    assign {ds, ls, hs, b} = {cur.dmux_source_select, cur.bmux_low_select,
                              cur.bmux_high_select, dp_i.b_reg};
    assign kc = B_CONST_TABLE[cur.b_constant_select];
    assign e_ba = cur.bus_addr_mux_select ? dp_i.alu_out : dp_i.read_bus;
    assign e_dm = ds == 2'h0 ? dp_i.read_bus : ds == 2'h1 ? dp_i.d_reg :
                  ds == 2'h2 ? dp_i.sys_bus : {dp_i.d_reg[15], dp_i.d_reg[15:1]};
    assign e_b[7:0] = ls == 2'h2 ? b[15:8] : ls == 2'h3 ? kc[7:0] : b[7:0];
    assign e_b[15:8] = hs == 2'h0 ? b[15:8] : hs == 2'h1 ? {8{b[7]}} :
                       hs == 2'h2 ? b[7:0] : {{4{kc[15]}}, kc[11], {3{kc[15]}}};
    assign e_op = cur.data_alteration_code[3:2] == ALT_IR_ALU ? dp_i.ir_alu_op :
                  {cur.alu_mode_select, cur.alu_function_select};
    assign len = uw.cycle_length_code == 2'h3 ? LONG_CYC :
                 uw.cycle_length_code == 2'h2 ? MEDIUM_CYC : SHORT_CYC;
    always_ff @(posedge clk_i)
    begin
        prev <= rom_word_i;
        uw   <= rst_i ? '0 : cur;
        ok   <= !rst_i && (ok || word_load_o);
        age  <= (rst_i || word_load_o) ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
    end
    sequence s_bus_word;
        word_load_o && cur.begin_bus_cycle;
    endsequence
    sequence s_bus_go;
        begin_bus_o && bus_ctl_o == $past(cur.bus_ctl);
    endsequence
    sequence s_next_word;
        word_load_o && ok && !uw.clock_stop;
    endsequence
    // ==========================================
    // assertions
    a_addr_mux: assert property (ok |-> bus_addr_data_o == $past(e_ba))
        else $error("address mux wrong");
    a_dmux_src: assert property (ok |-> dmux_o == $past(e_dm))
        else $error("d mux wrong");
    a_bmux_out: assert property (ok |-> alu_b_o == $past(e_b))
        else $error("b mux wrong");
    a_alu_op: assert property (ok |-> alu_op_o == $past(e_op))
        else $error("alu op wrong");
    a_bus_launch: assert property (s_bus_word |=> s_bus_go)
        else $error("bus cycle not begun");
    a_bus_hold: assert property (!begin_bus_o |-> $stable(bus_ctl_o))
        else $error("bus control moved");
    a_reg_pulse: assert property (s_next_word |-> {clk_bus_addr_o, clk_d_reg_o,
        clk_b_reg_o, write_low_o, write_high_o, clk_instr_reg_o} == {uw.bus_addr_clock_enable,
        uw.d_reg_clock_enable, uw.b_reg_clock_enable, uw.scratch_write_low,
        uw.scratch_write_high, uw.instr_reg_clock_enable})
        else $error("register pulse wrong");
    a_cycle_len: assert property (s_next_word |-> age == len - 4'h1)
        else $error("cycle length wrong");
    a_stop_halt: assert property (word_load_o && cur.clock_stop |=>
        (!word_load_o) [*8] ##1 (idle_o && !run_o))
        else $error("clock stop did not halt");
    a_load_runs: assert property (word_load_o |=> run_o && !idle_o)
        else $error("word loaded while idle");
endmodule
bind microword_control_decode uword_ctl_sva uword_ctl_sva_i (.clk_i, .rst_i, .rom_word_i,
    .dp_i, .word_load_o, .bus_addr_data_o, .dmux_o, .alu_b_o, .alu_op_o, .begin_bus_o,
    .bus_ctl_o, .clk_bus_addr_o, .clk_d_reg_o, .clk_b_reg_o, .write_low_o, .write_high_o,
    .clk_instr_reg_o, .run_o, .idle_o);

// >>> bench/uword_rom_model.sv
`timescale 1ns/1ps
// ==========================================
// microprogram store ahead of the buffer
module uword_rom_model
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 word_load_i,
    output uword_ctl_pkg::microword_t rom_word_o
);
    import uword_ctl_pkg::*;
    microword_t rom [32];
    logic [4:0] ptr;
    assign rom_word_o = rom[ptr];
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ptr <= 5'h0;
        else if (word_load_i)
            ptr <= ptr + 5'h1;
    end
endmodule

// >>> rtl/microword_control_decode.sv
`timescale 1ns/1ps
// Summary of operation
// - mux select high routes alu to address
// - two-bit code picks d-mux source
// - low codes 00/01 pass low b byte
// - low code 10 swaps upper b byte down
// - low code 11 feeds low b constants
// - high code 00 passes upper b byte
// - high code 01 replicates b bit seven
// - high code 10 swaps lower byte up
// - high code 11 feeds constant lines
// - four-bit field decodes sixteen b constants
// - alu from microword unless code 11xx
// - status select decoded bitwise and whole
// - alteration code enables bus exception checks
// - alteration codes set/clear examine, deposit flags
// - begin-bus with p1 launches bus cycle
// - bus control bits held for cycle
// - three bits gate register clock pulses
// - two bits gate scratch byte writes
// - instruction register clocked only when enabled
// - clock stop halts until external start
// - length code picks short, medium, long
// - lengths 140, 200, 300 ns nominal
// - control fields active high, uncomplemented
module microword_control_decode
(
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire uword_ctl_pkg::microword_t rom_word_i,
    input  wire uword_ctl_pkg::datapath_t  dp_i,
    input  wire logic                      start_i,
    input  wire logic                      npr_request_i,
    input  wire logic [3:0]                wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic                      wb_we_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    output logic [31:0]                    wb_dat_o,
    output logic                           wb_ack_o,
    output logic                           word_load_o,
    output logic [15:0]                    bus_addr_data_o,
    output logic [15:0]                    dmux_o,
    output logic [15:0]                    alu_b_o,
    output logic [4:0]                     alu_op_o,
    output logic                           ps_load_cc_o,
    output logic                           ps_cc_from_ir_o,
    output logic                           ps_load_word_o,
    output logic                           begin_bus_o,
    output logic [1:0]                     bus_ctl_o,
    output logic                           odd_error_o,
    output logic                           stack_error_o,
    output logic                           npr_grant_o,
    output logic                           clk_bus_addr_o,
    output logic                           clk_d_reg_o,
    output logic                           clk_b_reg_o,
    output logic                           write_low_o,
    output logic                           write_high_o,
    output logic                           clk_instr_reg_o,
    output logic                           examine_flag_o,
    output logic                           deposit_flag_o,
    output logic                           run_o,
    output logic                           idle_o,
    output logic [2:0]                     cycle_select_o,
    output logic                           overlap_permit_o
);
    import uword_ctl_pkg::*;

    // ==========================================================
    // functions
    function automatic logic [3:0] cycle_count(input logic [1:0] code);
        if (code == 2'b11)
            cycle_count = LONG_CYC;
        else if (code == 2'b10)
            cycle_count = MEDIUM_CYC;
        else
            cycle_count = SHORT_CYC;
    endfunction

    function automatic logic [15:0] bus_read_word(input logic [3:0] adr,
                                                  input logic [31:0] st,
                                                  input logic [15:0] lim,
                                                  input logic [31:0] wrd);
        if (adr == REG_STATUS)
            bus_read_word = st[15:0];
        else if (adr == REG_STACK_LIMIT)
            bus_read_word = lim;
        else if (adr == REG_WORD)
            bus_read_word = wrd[15:0];
        else
            bus_read_word = 16'h0000;
    endfunction

    // ==========================================================
    // declarations
    microword_t  uw;
    seq_state_t  state;
    logic [3:0]  cyc_cnt;
    logic        p1;
    logic        start_meta;
    logic        start_sync;
    logic        start_prev;
    logic        npr_meta;
    logic        npr_sync;
    logic        soft_start;
    logic        err_clear;
    logic [15:0] stack_limit;
    logic        last;
    logic        start_evt;
    logic        load;
    logic [15:0] b_const;
    logic        bus_wr;
    logic [31:0] status_word;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_prev <= 1'b0;
            npr_meta   <= 1'b0;
            npr_sync   <= 1'b0;
        end
        else
        begin
            start_meta <= start_i;
            start_sync <= start_meta;
            start_prev <= start_sync;
            npr_meta   <= npr_request_i;
            npr_sync   <= npr_meta;
        end
    end

    assign last      = (state == ST_RUN) && (cyc_cnt == 4'h1);
    assign start_evt = (state == ST_IDLE) && ((start_sync && !start_prev) || soft_start);
    assign load      = start_evt || (last && !uw.clock_stop);

    // ==========================================================
    // run / idle sequencer and cycle timer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state   <= ST_IDLE;
            cyc_cnt <= 4'h0;
            p1      <= 1'b0;
        end
        else
        begin
            p1 <= load;
            case (state)
                ST_IDLE:
                begin
                    if (start_evt)
                    begin
                        state   <= ST_RUN;
                        cyc_cnt <= cycle_count(rom_word_i.cycle_length_code);
                    end
                end
                ST_RUN:
                begin
                    if (last && uw.clock_stop)
                    begin
                        state   <= ST_IDLE;
                        cyc_cnt <= 4'h0;
                    end
                    else if (last)
                        cyc_cnt <= cycle_count(rom_word_i.cycle_length_code);
                    else
                        cyc_cnt <= cyc_cnt - 4'h1;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // microword buffer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            uw <= '0;
        else if (load)
            uw <= rom_word_i;
    end

    // ==========================================================
    // datapath steering
    assign b_const = B_CONST_TABLE[uw.b_constant_select];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bus_addr_data_o <= 16'h0000;
            dmux_o          <= 16'h0000;
            alu_b_o         <= 16'h0000;
            alu_op_o        <= 5'h00;
        end
        else
        begin
            bus_addr_data_o <= uw.bus_addr_mux_select ? dp_i.alu_out : dp_i.read_bus;
            case (uw.dmux_source_select)
                2'b00:   dmux_o <= dp_i.read_bus;
                2'b01:   dmux_o <= dp_i.d_reg;
                2'b10:   dmux_o <= dp_i.sys_bus;
                default: dmux_o <= {dp_i.d_reg[15], dp_i.d_reg[15:1]};
            endcase
            case (uw.bmux_low_select)
                2'b00, 2'b01: alu_b_o[7:0] <= dp_i.b_reg[7:0];
                2'b10:        alu_b_o[7:0] <= dp_i.b_reg[15:8];
                default:      alu_b_o[7:0] <= b_const[7:0];
            endcase
            case (uw.bmux_high_select)
                2'b00:   alu_b_o[15:8] <= dp_i.b_reg[15:8];
                2'b01:   alu_b_o[15:8] <= {8{dp_i.b_reg[7]}};
                2'b10:   alu_b_o[15:8] <= dp_i.b_reg[7:0];
                default: alu_b_o[15:8] <= {{4{b_const[15]}}, b_const[11], {3{b_const[15]}}};
            endcase
            if (uw.data_alteration_code[3:2] == ALT_IR_ALU)
                alu_op_o <= dp_i.ir_alu_op;
            else
                alu_op_o <= {uw.alu_mode_select, uw.alu_function_select};
        end
    end

    // ==========================================================
    // processor status control
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ps_load_cc_o    <= 1'b0;
            ps_cc_from_ir_o <= 1'b0;
            ps_load_word_o  <= 1'b0;
        end
        else
        begin
            ps_load_cc_o    <= last && uw.proc_status_select[0];
            ps_cc_from_ir_o <= uw.proc_status_select[1];
            ps_load_word_o  <= last && (uw.proc_status_select == PS_LOAD_WORD);
        end
    end

    // ==========================================================
    // bus cycle start, checks and holding bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            begin_bus_o   <= 1'b0;
            bus_ctl_o     <= 2'b00;
            odd_error_o   <= 1'b0;
            stack_error_o <= 1'b0;
            npr_grant_o   <= 1'b0;
        end
        else
        begin
            begin_bus_o <= p1 && uw.begin_bus_cycle;
            if (p1 && uw.begin_bus_cycle)
            begin
                bus_ctl_o   <= uw.bus_ctl;
                npr_grant_o <= npr_sync;
                odd_error_o <= dp_i.alu_out[0] &&
                    ((uw.data_alteration_code == ALT_ODD_CHK) ||
                     (uw.data_alteration_code == ALT_BOTH_CHK));
                stack_error_o <= (dp_i.alu_out < stack_limit) &&
                    ((uw.data_alteration_code == ALT_STACK_CHK) ||
                     (uw.data_alteration_code == ALT_BOTH_CHK));
            end
            else if (err_clear)
            begin
                odd_error_o   <= 1'b0;
                stack_error_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // register clock and write pulses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_bus_addr_o  <= 1'b0;
            clk_d_reg_o     <= 1'b0;
            clk_b_reg_o     <= 1'b0;
            write_low_o     <= 1'b0;
            write_high_o    <= 1'b0;
            clk_instr_reg_o <= 1'b0;
            word_load_o     <= 1'b0;
        end
        else
        begin
            clk_bus_addr_o  <= last && uw.bus_addr_clock_enable;
            clk_d_reg_o     <= last && uw.d_reg_clock_enable;
            clk_b_reg_o     <= last && uw.b_reg_clock_enable;
            write_low_o     <= last && uw.scratch_write_low;
            write_high_o    <= last && uw.scratch_write_high;
            clk_instr_reg_o <= last && uw.instr_reg_clock_enable;
            word_load_o     <= load;
        end
    end

    // ==========================================================
    // console examine / deposit flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            examine_flag_o <= 1'b0;
            deposit_flag_o <= 1'b0;
        end
        else if (last)
        begin
            if (uw.data_alteration_code == ALT_SET_EXAM)
                examine_flag_o <= 1'b1;
            else if (uw.data_alteration_code == ALT_CLR_EXAM)
                examine_flag_o <= 1'b0;
            if (uw.data_alteration_code == ALT_SET_DEP)
                deposit_flag_o <= 1'b1;
            else if (uw.data_alteration_code == ALT_CLR_DEP)
                deposit_flag_o <= 1'b0;
        end
    end

    // ==========================================================
    // clock status outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_o            <= 1'b0;
            idle_o           <= 1'b1;
            cycle_select_o   <= 3'b000;
            overlap_permit_o <= 1'b0;
        end
        else
        begin
            run_o            <= (state == ST_RUN);
            idle_o           <= (state == ST_IDLE);
            cycle_select_o   <= (state != ST_RUN) ? 3'b000 :
                                (uw.cycle_length_code == 2'b11) ? 3'b100 :
                                (uw.cycle_length_code == 2'b10) ? 3'b010 : 3'b001;
            overlap_permit_o <= (state == ST_RUN) && (uw.cycle_length_code == 2'b00);
        end
    end

    // ==========================================================
    // wishbone slave
    assign bus_wr      = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign status_word = {16'h0000, 4'h0, npr_sync, bus_ctl_o, begin_bus_o,
                          stack_error_o, odd_error_o, deposit_flag_o, examine_flag_o,
                          cycle_select_o, run_o};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
            soft_start  <= 1'b0;
            err_clear   <= 1'b0;
            stack_limit <= STACK_LIMIT_RST;
        end
        else
        begin
            wb_ack_o   <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o   <= {16'h0000, bus_read_word(wb_adr_i, status_word, stack_limit,
                                                   32'(uw))};
            soft_start <= 1'b0;
            err_clear  <= 1'b0;
            if (bus_wr && (wb_adr_i == REG_CONTROL) && wb_sel_i[0])
            begin
                soft_start <= wb_dat_i[CTL_START];
                err_clear  <= wb_dat_i[CTL_ERRCLR];
            end
            else if (bus_wr && (wb_adr_i == REG_STACK_LIMIT))
            begin
                if (wb_sel_i[0])
                    stack_limit[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    stack_limit[15:8] <= wb_dat_i[15:8];
            end
        end
    end

endmodule

// >>> rtl/uword_ctl_pkg.sv
package uword_ctl_pkg;

    // ==========================================================
    // microword control fields, all active high in the buffer
    typedef struct packed {
        logic       clock_stop;
        logic [1:0] cycle_length_code;
        logic       instr_reg_clock_enable;
        logic       scratch_write_high;
        logic       scratch_write_low;
        logic       b_reg_clock_enable;
        logic       d_reg_clock_enable;
        logic       bus_addr_clock_enable;
        logic       begin_bus_cycle;
        logic [1:0] bus_ctl;
        logic [3:0] data_alteration_code;
        logic [2:0] proc_status_select;
        logic       alu_mode_select;
        logic [3:0] alu_function_select;
        logic [3:0] b_constant_select;
        logic [1:0] bmux_high_select;
        logic [1:0] bmux_low_select;
        logic [1:0] dmux_source_select;
        logic       bus_addr_mux_select;
    } microword_t;

    // ==========================================================
    // datapath values seen by the multiplexers
    typedef struct packed {
        logic [15:0] read_bus;
        logic [15:0] d_reg;
        logic [15:0] sys_bus;
        logic [15:0] b_reg;
        logic [15:0] alu_out;
        logic [4:0]  ir_alu_op;
    } datapath_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } seq_state_t;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SHORT_NS      = 140;
    localparam int MEDIUM_NS     = 200;
    localparam int LONG_NS       = 300;
    localparam logic [3:0] SHORT_CYC  = 4'((SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] MEDIUM_CYC = 4'((MEDIUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] LONG_CYC   = 4'((LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // data-alteration codes
    localparam logic [3:0] ALT_NONE      = 4'h0;
    localparam logic [3:0] ALT_ODD_CHK   = 4'h1;
    localparam logic [3:0] ALT_STACK_CHK = 4'h2;
    localparam logic [3:0] ALT_BOTH_CHK  = 4'h3;
    localparam logic [3:0] ALT_SET_EXAM  = 4'h4;
    localparam logic [3:0] ALT_CLR_EXAM  = 4'h5;
    localparam logic [3:0] ALT_SET_DEP   = 4'h6;
    localparam logic [3:0] ALT_CLR_DEP   = 4'h7;
    localparam logic [1:0] ALT_IR_ALU    = 2'h3;

    // processor-status select: whole-code load
    localparam logic [2:0] PS_LOAD_WORD = 3'h7;

    // ==========================================================
    // registers
    localparam logic [3:0]  REG_CONTROL     = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_STACK_LIMIT = 4'h8;
    localparam logic [3:0]  REG_WORD        = 4'hc;
    localparam logic [15:0] STACK_LIMIT_RST = 16'h0400;
    localparam int CTL_START  = 0;
    localparam int CTL_ERRCLR = 1;

    // ==========================================================
    // b constants table
    localparam logic [15:0] B_CONST_TABLE [16] = '{
        16'h0000, 16'h0001, 16'h0002, 16'h0003,
        16'h0004, 16'h0006, 16'h0008, 16'h000a,
        16'h0010, 16'h0014, 16'h0018, 16'h001c,
        16'h0080, 16'h0800, 16'hfffe, 16'hffff
    };

endpackage
